// >>> calc_pkg.sv
package calc_pkg;
   // register pointer values
   localparam logic [7:0] PTR_CONFIG = 8'h00;
   localparam logic [7:0] PTR_SHUNT = 8'h01;
   localparam logic [7:0] PTR_BUS = 8'h02;
   localparam logic [7:0] PTR_POWER = 8'h03;
   localparam logic [7:0] PTR_CURRENT = 8'h04;
   localparam logic [7:0] PTR_CAL = 8'h05;
   // configuration word after power-up: 32 V range, gain /8, 12-bit, continuous both
   localparam logic [15:0] CONFIG_RESET = 16'h399F;
   localparam int CFG_RST_BIT = 15;
   localparam int CFG_BRNG_BIT = 13;
   localparam int CFG_GAIN_LSB = 11;
   localparam int CFG_BADC_LSB = 7;
   localparam int CFG_SADC_LSB = 3;
   localparam int CFG_MODE_LSB = 0;
   localparam logic [15:0] CAL_RESET = 16'h0000;
   // bus code sits left-shifted in its register, one count is 4 mV
   localparam int BUS_SHIFT = 3;
   localparam int BUS_LSB_MV = 4;
   localparam int SHUNT_LSB_UV = 10;
   localparam int POWER_LSB_RATIO = 20;
   localparam logic signed [16:0] CURRENT_DIV = 17'sh01000;
   localparam logic signed [16:0] POWER_DIV = 17'sh01388;
   // interface watchdog
   localparam int CLK_HZ = 100_000_000;
   localparam int TIMEOUT_MS = 28;
   localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
   // device address, value is arbitrary
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

   // product of two values, integer-divided with the remainder dropped, kept at 16 bits
   function automatic logic [15:0] mul_div(input logic signed [16:0] a,
                                           input logic signed [16:0] b,
                                           input logic signed [16:0] d);
      logic signed [33:0] p;
      logic signed [33:0] q;
      p = a * b;
      q = p / 34'(d);
      mul_div = q[15:0];
   endfunction : mul_div
endpackage : calc_pkg

// >>> calc_engine.sv
`timescale 1ns/1ps
`default_nettype none
module calc_engine (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [15:0] shunt_code,
   input wire logic [12:0] bus_code,
   input wire logic [15:0] cal,
   input wire logic cal_valid,
   output logic [15:0] current_result,
   output logic [15:0] power_result
);
   import calc_pkg::*;

   logic stage2_reg;
   logic [12:0] bus_hold_reg;
   wire logic [15:0] current_next;
   wire logic [15:0] power_next;

   // pipelined after the conversion, so the arithmetic never stretches it
   assign current_next = cal_valid ? mul_div(17'(signed'(shunt_code)), signed'({1'b0, cal}),
                                             CURRENT_DIV) : 16'h0000;
   assign power_next = cal_valid ? mul_div(17'(signed'(current_result)),
                                           signed'({4'h0, bus_hold_reg}),
                                           POWER_DIV) : 16'h0000;

   // stage one: current, stage two: power from the fresh current
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage2_reg <= 1'b0;
         bus_hold_reg <= 13'h0000;
         current_result <= 16'h0000;
         power_result <= 16'h0000;
      end else begin
         stage2_reg <= start;
         if (start) begin
            current_result <= current_next;
            bus_hold_reg <= bus_code;
         end
         if (stage2_reg) begin
            power_result <= power_next;
         end
         if (!cal_valid) begin
            current_result <= 16'h0000;
            power_result <= 16'h0000;
         end
      end
   end
endmodule : calc_engine
`default_nettype wire

// >>> power_monitor.sv
// Functional notes
// - current equals shunt times calibration over 4096
// - power equals current times bus over 5000
// - power step is twenty current steps
// - bus code stored shifted up three bits
// - one shunt count is 10 microvolts
// - current and power meaningless until calibrated
// - uncalibrated current and power read zero
// - power-up: 12-bit, /8, 32 V, continuous
// - lines only pulled low, never driven high
// - address sampled on rising clock, last bit direction
// - addressed device acknowledges on ninth pulse
// - eight data bits then one acknowledge
// - data moves only while clock low
// - stalled transaction over 28 ms resets interface
// - words travel high byte first
// - arithmetic runs in background of conversions
`timescale 1ns/1ps
`default_nettype none
module power_monitor #(
   parameter logic [6:0] DEV_ADDR = calc_pkg::DEV_ADDR_DEFAULT,
   parameter int TIMEOUT_CYC = calc_pkg::TIMEOUT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic conv_done,
   input wire logic [15:0] shunt_code,
   input wire logic [12:0] bus_code,
   output logic bus_range_32v,
   output logic [1:0] shunt_gain_select,
   output logic [3:0] bus_adc_setting,
   output logic [3:0] shunt_adc_setting,
   output logic [2:0] op_mode
);
   import calc_pkg::*;

   typedef enum logic [2:0] {st_idle, st_addr, st_ptr, st_wr, st_rd} link_state_t;
   localparam int TO_W = $clog2(TIMEOUT_CYC + 1);

   link_state_t state_reg;
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] ptr_reg;
   logic [7:0] hi_byte_reg;
   logic [7:0] tx_reg;
   logic byte_sel_reg;
   logic ack_ok_reg;
   logic [TO_W-1:0] idle_cnt_reg;
   logic [15:0] config_reg;
   logic [15:0] cal_reg;
   logic cal_valid_reg;
   logic [15:0] shunt_reg;
   logic [12:0] bus_reg;
   logic calc_start_reg;
   logic [15:0] current_result;
   logic [15:0] power_result;

   // second and third stages feed the edge logic; the second data stage is also the sampled bit
   wire logic scl_rise = scl_s & ~scl_d;
   wire logic scl_fall = ~scl_s & scl_d;
   wire logic start_cond = scl_s & scl_d & sda_d & ~sda_s;
   wire logic stop_cond = scl_s & scl_d & ~sda_d & sda_s;
   wire logic timed_out = (idle_cnt_reg == TO_W'(TIMEOUT_CYC));
   wire logic addr_hit = (shift_reg[7:1] == DEV_ADDR);
   wire logic [15:0] bus_word = {bus_reg, {BUS_SHIFT{1'b0}}};
   wire logic [15:0] wr_word = {hi_byte_reg, shift_reg};
   wire logic wr_config = (state_reg == st_wr) && byte_sel_reg && (ptr_reg == PTR_CONFIG);
   wire logic wr_cal = (state_reg == st_wr) && byte_sel_reg && (ptr_reg == PTR_CAL);
   wire logic byte_end = scl_fall && (bit_cnt_reg == 4'h8);
   wire logic frame_end = scl_fall && (bit_cnt_reg == 4'h9);
   wire logic [15:0] rd_word;

   // read selection by the stored pointer; shunt count weighs 10 uV
   assign rd_word = (ptr_reg == PTR_CONFIG) ? config_reg :
                    (ptr_reg == PTR_SHUNT) ? shunt_reg :
                    (ptr_reg == PTR_BUS) ? bus_word :
                    (ptr_reg == PTR_POWER) ? power_result :
                    (ptr_reg == PTR_CURRENT) ? current_result :
                    (ptr_reg == PTR_CAL) ? cal_reg : 16'h0000;

   // configuration fields steer the converter
   assign bus_range_32v = config_reg[CFG_BRNG_BIT];
   assign shunt_gain_select = config_reg[CFG_GAIN_LSB +: 2];
   assign bus_adc_setting = config_reg[CFG_BADC_LSB +: 4];
   assign shunt_adc_setting = config_reg[CFG_SADC_LSB +: 4];
   assign op_mode = config_reg[CFG_MODE_LSB +: 3];

   // pins come from another domain: two flops, then a delay stage for edges
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
      end
   end

   // the clock line is never driven and data is only pulled low
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_o <= 1'b0;
         scl_oe <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         scl_o <= 1'b0;
         scl_oe <= 1'b0;
         sda_o <= 1'b0;
      end
   end

   // stall watchdog: any line movement restarts it, only busy states count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt_reg <= '0;
      end else if (state_reg == st_idle || scl_s != scl_d || sda_s != sda_d || timed_out) begin
         idle_cnt_reg <= '0;
      end else begin
         idle_cnt_reg <= idle_cnt_reg + TO_W'(1);
      end
   end

   // serial framing: bits counted on rising clock, line driven after falling clock
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= st_idle;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= PTR_CONFIG;
         hi_byte_reg <= 8'h00;
         tx_reg <= 8'h00;
         byte_sel_reg <= 1'b0;
         ack_ok_reg <= 1'b0;
         sda_oe <= 1'b0;
      end else if (timed_out || stop_cond) begin
         state_reg <= st_idle;
         sda_oe <= 1'b0;
      end else if (start_cond) begin
         state_reg <= st_addr;
         bit_cnt_reg <= 4'h0;
         byte_sel_reg <= 1'b0;
         sda_oe <= 1'b0;
      end else if (state_reg != st_idle) begin
         if (scl_rise) begin
            if (bit_cnt_reg < 4'h8) begin
               shift_reg <= {shift_reg[6:0], sda_s};
            end else begin
               ack_ok_reg <= ~sda_s; // master acknowledge in read
            end
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end else if (byte_end) begin
            // ninth clock: acknowledge every byte the master writes, except an address that does not match
            sda_oe <= (state_reg != st_rd);
            if (state_reg == st_addr && !addr_hit) begin
               state_reg <= st_idle;
               sda_oe <= 1'b0;
            end
         end else if (frame_end) begin
            bit_cnt_reg <= 4'h0;
            sda_oe <= 1'b0;
            case (state_reg)
               st_addr: begin
                  state_reg <= shift_reg[0] ? st_rd : st_ptr;
                  if (shift_reg[0]) begin
                     tx_reg <= rd_word[15:8];
                     byte_sel_reg <= 1'b1;
                     sda_oe <= ~rd_word[15];
                  end
               end
               st_ptr: begin
                  ptr_reg <= shift_reg;
                  state_reg <= st_wr;
               end
               st_wr: begin
                  hi_byte_reg <= shift_reg; // high byte arrives first
                  byte_sel_reg <= ~byte_sel_reg;
               end
               st_rd: begin
                  // a not-acknowledge lets go of the line until the next start
                  if (ack_ok_reg) begin
                     tx_reg <= byte_sel_reg ? rd_word[7:0] : rd_word[15:8];
                     sda_oe <= byte_sel_reg ? ~rd_word[7] : ~rd_word[15];
                     byte_sel_reg <= ~byte_sel_reg;
                  end else begin
                     state_reg <= st_idle;
                  end
               end
               default: state_reg <= st_idle;
            endcase
         end else if (scl_fall && state_reg == st_rd && bit_cnt_reg < 4'h8) begin
            sda_oe <= ~tx_reg[3'(4'h7 - bit_cnt_reg)];
         end
      end
   end

   // configuration: power-up defaults, reset bit restores them and clears itself
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         config_reg <= CONFIG_RESET;
      end else if (frame_end && wr_config) begin
         config_reg <= wr_word[CFG_RST_BIT] ? CONFIG_RESET : wr_word;
      end
   end

   // calibration: results stay invalid until software programs a nonzero value
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cal_reg <= CAL_RESET;
         cal_valid_reg <= 1'b0;
      end else if (frame_end && wr_config && wr_word[CFG_RST_BIT]) begin
         cal_reg <= CAL_RESET;
         cal_valid_reg <= 1'b0;
      end else if (frame_end && wr_cal) begin
         cal_reg <= wr_word;
         cal_valid_reg <= (wr_word != 16'h0000);
      end
   end

   // conversion results latched, arithmetic kicked off one cycle later
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         shunt_reg <= 16'h0000;
         bus_reg <= 13'h0000;
         calc_start_reg <= 1'b0;
      end else begin
         calc_start_reg <= conv_done;
         if (conv_done) begin
            shunt_reg <= shunt_code;
            bus_reg <= bus_code;
         end
      end
   end

   calc_engine engine (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(calc_start_reg),
      .shunt_code(shunt_reg),
      .bus_code(bus_reg),
      .cal(cal_reg),
      .cal_valid(cal_valid_reg),
      .current_result(current_result),
      .power_result(power_result)
   );
endmodule : power_monitor
`default_nettype wire

// >>> power_monitor_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module power_monitor_checker #(
   parameter int TIMEOUT_CYC = 200
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic conv_done,
   input wire logic [15:0] shunt_code,
   input wire logic [12:0] bus_code,
   input wire logic bus_range_32v,
   input wire logic [1:0] shunt_gain_select,
   input wire logic [3:0] bus_adc_setting,
   input wire logic [3:0] shunt_adc_setting,
   input wire logic [2:0] op_mode
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [1:0] lines_reg;
   int quiet_cnt;
   logic [13:0] cfg;
   assign cfg = {bus_range_32v, shunt_gain_select, bus_adc_setting, shunt_adc_setting, op_mode};
   // frozen-line counter; margin covers the two-flop line synchronisers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lines_reg <= 2'h3;
         quiet_cnt <= 0;
      end else begin
         lines_reg <= {scl_i, sda_i};
         quiet_cnt <= ({scl_i, sda_i} != lines_reg) ? 0 : quiet_cnt + 1;
      end
   end
   a_scl_never_driven: assert property (!scl_oe && !scl_o)
      else $error("clock line driven");
   a_sda_pull_only: assert property (sda_oe |-> !sda_o)
      else $error("data driven high");
   a_reset_cfg_default: assert property ($rose(rst_n) |-> cfg == 14'h399F)
      else $error("config not default after reset");
   a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_i)
      else $error("data moved, clock high");
   a_oe_steady_high: assert property (scl_i [*4] |-> $stable(sda_oe))
      else $error("data changed while clock high");
   a_ack_fall_low: assert property ($fell(sda_oe) |-> !scl_i)
      else $error("release with clock high");
   a_oe_min_hold: assert property ($rose(sda_oe) |=> sda_oe [*4])
      else $error("pull too short");
   a_cfg_commit_low: assert property ($changed(cfg) |-> !scl_i)
      else $error("config moved mid bit");
   a_stall_release: assert property (quiet_cnt > TIMEOUT_CYC + 8 |-> !sda_oe)
      else $error("line held after stall");
   c_ack_seen: cover property ($rose(sda_oe));
   c_stall_seen: cover property (sda_oe && quiet_cnt == TIMEOUT_CYC);
   c_conv_seen: cover property (conv_done ##1 !conv_done);
endmodule : power_monitor_checker
bind power_monitor power_monitor_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .conv_done(conv_done),
   .shunt_code(shunt_code), .bus_code(bus_code), .bus_range_32v(bus_range_32v),
   .shunt_gain_select(shunt_gain_select), .bus_adc_setting(bus_adc_setting),
   .shunt_adc_setting(shunt_adc_setting), .op_mode(op_mode));
`default_nettype wire

// >>> serial_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_master_model #(
   parameter logic [6:0] ADDR = calc_pkg::DEV_ADDR_DEFAULT
) (
   input wire logic ref_clk,
   input wire logic sda_line,
   output logic scl_low,
   output logic sda_low
);
   // lines start released; the pull-ups hold them high
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic hp();
      repeat (6) @(negedge ref_clk);
   endtask : hp
   task automatic start();
      hp();
      sda_low = 1'b0;
      hp();
      scl_low = 1'b0;
      hp();
      sda_low = 1'b1;
      hp();
      scl_low = 1'b1;
   endtask : start
   task automatic stop();
      hp();
      sda_low = 1'b1;
      hp();
      scl_low = 1'b0;
      hp();
      sda_low = 1'b0;
      hp();
   endtask : stop
   // data only moves a half phase after the clock fell
   task automatic bit_io(input logic b, output logic r);
      hp();
      sda_low = !b;
      hp();
      scl_low = 1'b0;
      hp();
      r = sda_line;
      scl_low = 1'b1;
   endtask : bit_io
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(v[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask : wbyte
   task automatic rbyte(input logic last, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         v[i] = r;
      end
      bit_io(last, r);
   endtask : rbyte
   task automatic write_reg(input logic [7:0] p, input logic [15:0] d, output logic ok);
      logic a0, a1, a2, a3;
      start();
      wbyte({ADDR, 1'b0}, a0);
      wbyte(p, a1);
      wbyte(d[15:8], a2);
      wbyte(d[7:0], a3);
      stop();
      ok = a0 & a1 & a2 & a3;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] p, output logic [15:0] d);
      logic a;
      start();
      wbyte({ADDR, 1'b0}, a);
      wbyte(p, a);
      start();
      wbyte({ADDR, 1'b1}, a);
      rbyte(1'b0, d[15:8]);
      rbyte(1'b1, d[7:0]);
      stop();
   endtask : read_reg
endmodule : serial_master_model
`default_nettype wire

// >>> power_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module power_monitor_tb_top;
   import calc_pkg::*;
   localparam int TO = 200;
   logic ref_clk, rst_n, conv_done, scl_low, sda_low, scl_w, sda_w, scl_o, scl_oe, sda_o, sda_oe;
   logic [15:0] shunt_code, s, c, ec;
   logic [12:0] bus_code, b;
   logic bus_range_32v, ack, r;
   logic [1:0] shunt_gain_select;
   logic [3:0] bus_adc_setting, shunt_adc_setting;
   logic [2:0] op_mode;
   // configuration outputs gathered in register bit order
   wire logic [13:0] cfg_out = {bus_range_32v, shunt_gain_select, bus_adc_setting,
                                shunt_adc_setting, op_mode};
   int error_cnt, checks_done, seed;
   // open-drain wires: low if anyone pulls
   assign scl_w = !(scl_low || scl_oe);
   assign sda_w = !(sda_low || sda_oe);
   power_monitor #(.TIMEOUT_CYC(TO)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .conv_done(conv_done), .shunt_code(shunt_code), .bus_code(bus_code),
      .bus_range_32v(bus_range_32v), .shunt_gain_select(shunt_gain_select),
      .bus_adc_setting(bus_adc_setting), .shunt_adc_setting(shunt_adc_setting), .op_mode(op_mode));
   serial_master_model i_mst (.ref_clk(ref_clk), .sda_line(sda_w), .scl_low(scl_low),
      .sda_low(sda_low));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = !ref_clk;
   end
   function automatic logic [15:0] exp_cur(logic [15:0] sh, logic [15:0] ca);
      return 16'(longint'($signed(sh)) * longint'(ca) / 4096);
   endfunction : exp_cur
   function automatic logic [15:0] exp_pow(logic [15:0] cu, logic [12:0] bu);
      return 16'(longint'($signed(cu)) * longint'(bu) / 5000);
   endfunction : exp_pow
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task automatic expect_reg(input logic [7:0] p, input logic [15:0] e);
      logic [15:0] d;
      i_mst.read_reg(p, d);
      `CHK(d, e)
   endtask : expect_reg
   task automatic convert(input logic [15:0] sh, input logic [12:0] bu);
      @(negedge ref_clk);
      shunt_code = sh;
      bus_code = bu;
      conv_done = 1'b1;
      @(negedge ref_clk);
      conv_done = 1'b0;
      repeat (5) @(negedge ref_clk);
   endtask : convert
   // hang guard
   initial begin
      repeat (100000) @(posedge ref_clk);
      error_cnt++;
      $display("wrong value at %0t: run hung", $time);
      summarize();
   end
   initial begin
      seed = 32'h886096ED;
      error_cnt = 0;
      checks_done = 0;
      rst_n = 1'b0;
      conv_done = 1'b0;
      shunt_code = 16'h0000;
      bus_code = 13'h0000;
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      convert(16'h1234, 13'h0FA0);
      expect_reg(PTR_CONFIG, CONFIG_RESET);
      expect_reg(PTR_CURRENT, 16'h0000);
      expect_reg(PTR_POWER, 16'h0000);
      expect_reg(PTR_SHUNT, 16'h1234);
      expect_reg(PTR_BUS, 16'h7D00);
      i_mst.write_reg(PTR_CAL, 16'h0001, ack); // unknown address follows
      i_mst.start();
      i_mst.wbyte({7'h2B, 1'b0}, ack);
      i_mst.stop();
      `CHK(ack, 1'b0)
      $display("test uncalibrated done");
      for (int k = 0; k < 8; k++) begin
         s = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h8000 : 16'($random(seed));
         c = (k == 0) ? 16'h0001 : (k == 1) ? 16'h1000 : 16'($random(seed)) & 16'h0FFF | 16'h0001;
         b = (k < 2) ? 13'h1FFF : 13'($random(seed));
         i_mst.write_reg(PTR_CAL, c, ack);
         `CHK(ack, 1'b1)
         convert(s, b);
         ec = exp_cur(s, c);
         expect_reg(PTR_CURRENT, ec);
         expect_reg(PTR_POWER, exp_pow(ec, b));
      end
      $display("test arithmetic done");
      i_mst.write_reg(PTR_CURRENT, 16'hFFFF, ack);
      expect_reg(PTR_CURRENT, ec);
      expect_reg(8'h07, 16'h0000);
      i_mst.write_reg(PTR_CONFIG, 16'h0123, ack);
      `CHK(cfg_out, 14'h0123)
      i_mst.write_reg(PTR_CONFIG, 16'h8000, ack);
      `CHK(cfg_out, 14'h399F)
      convert(16'h4000, 13'h0100);
      expect_reg(PTR_CURRENT, 16'h0000);
      $display("test config done");
      // 1 mA step covers 32 A, rounded up; a 10 mOhm shunt then gives 4096
      i_mst.write_reg(PTR_CAL, 16'h1000, ack);
      convert(16'h03E8, 13'h0800);
      expect_reg(PTR_CURRENT, exp_cur(16'h03E8, 16'h1000));
      // meter reads 1010 where 1000 was reported: scale calibration by that ratio
      c = 16'(32'h1000 * 32'h03F2 / 32'h03E8);
      i_mst.write_reg(PTR_CAL, c, ack);
      expect_reg(PTR_CAL, c);
      convert(16'h03E8, 13'h0800);
      expect_reg(PTR_CURRENT, exp_cur(16'h03E8, c));
      // a zero calibration counts as unprogrammed
      i_mst.write_reg(PTR_CAL, 16'h0000, ack);
      convert(16'h03E8, 13'h0800);
      expect_reg(PTR_POWER, 16'h0000);
      $display("test trim done");
      i_mst.start();
      for (int i = 7; i >= 0; i--) i_mst.bit_io(i == 0 ? 1'b0 : DEV_ADDR_DEFAULT[i - 1], r);
      repeat (5) @(negedge ref_clk);
      `CHK(sda_oe, 1'b1)
      repeat (TO + 30) @(negedge ref_clk);
      `CHK(sda_oe, 1'b0)
      i_mst.stop();
      expect_reg(PTR_CONFIG, CONFIG_RESET);
      $display("test stall done");
      summarize();
   end
endmodule : power_monitor_tb_top
`default_nettype wire
